// ===== bench/sce_closure_extender_asserts.sv
`timescale 1ns/1ns
module sce_closure_extender_asserts
  import sce_pkg::*;
#(
  parameter int unsigned SAMPLE_CYCLES = 32'(SAMPLE_CYC)
) (
  input wire logic clock, // Clock
  input wire logic srst, // Reset
  input wire logic safing_sense_in, // Sense
  input wire logic firing_enable_line_in, // Wire
  input wire logic closure_flag_out, // Flag
  input wire logic firing_enable_line_out, // Drive
  input wire logic firing_enable_line_oe, // Pull
  input wire logic firing_enable_seen // Seen
);
  int unsigned cnt_ff;
  int unsigned nxt_cnt;
  always_comb begin
    nxt_cnt = firing_enable_line_oe ? cnt_ff + 1 : 0;
  end
  always_ff @(posedge clock) begin
    cnt_ff <= srst ? 0 : nxt_cnt;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  property p_od; !firing_enable_line_out; endproperty
  a_od: assert property (p_od) else $error("line driven high");
  property p_rst;
    disable iff (1'b0) srst |=> !closure_flag_out && !firing_enable_line_oe && firing_enable_seen;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  property p_low; !safing_sense_in [*7] |-> closure_flag_out; endproperty
  a_low: assert property (p_low) else $error("closure not shown");
  property p_seen;
    $stable(firing_enable_line_in) [*6] |-> firing_enable_seen == firing_enable_line_in;
  endproperty
  a_seen: assert property (p_seen) else $error("seen level");
  property p_oe_flag; firing_enable_line_oe |-> closure_flag_out; endproperty
  a_oe_flag: assert property (p_oe_flag) else $error("pull without flag");
  property p_start; $rose(firing_enable_line_oe) |-> $past(closure_flag_out); endproperty
  a_start: assert property (p_start) else $error("start without closure");
  property p_ext;
    $fell(firing_enable_line_oe) |-> cnt_ff >= ADD_TICKS * SAMPLE_CYCLES;
  endproperty
  a_ext: assert property (p_ext) else $error("extension short");
  property p_fall; $fell(closure_flag_out) |-> !$past(firing_enable_line_oe); endproperty
  a_fall: assert property (p_fall) else $error("flag fell early");
  c_ext: cover property ($rose(firing_enable_line_oe));
  c_end: cover property ($fell(firing_enable_line_oe));
  c_seen: cover property ($fell(firing_enable_seen));
endmodule // sce_closure_extender_asserts
bind sce_closure_extender sce_closure_extender_asserts #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) u_chk (
  .clock(clock), .srst(srst), .safing_sense_in(safing_sense_in),
  .firing_enable_line_in(firing_enable_line_in), .closure_flag_out(closure_flag_out),
  .firing_enable_line_out(firing_enable_line_out),
  .firing_enable_line_oe(firing_enable_line_oe), .firing_enable_seen(firing_enable_seen));

// ===== bench/sce_mcu_model.sv
`timescale 1ns/1ns
module sce_mcu_model (
  input wire logic dut_oe, // Device pulls low
  input wire logic dut_out, // Level the device drives when enabled
  input wire logic test_pull, // Controller test pull
  output logic line // Wire level
);
  // Pull-up on the wire, so any party pulling low wins
  assign line = !((dut_oe && !dut_out) || test_pull);
endmodule // sce_mcu_model

// ===== bench/tb.sv
`timescale 1ns/1ns
module tb;
  // Short tick keeps the 193-tick extension to a few hundred cycles
  localparam int SC = 4;
  localparam int EXT = 193 * SC;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic sense = 1'b1;
  logic pull = 1'b0;
  logic line, flag, od, oe, seen;
  int errors = 0;
  int checks = 0;
  int n;
  always #4 clock = ~clock;
  sce_closure_extender #(.SAMPLE_CYCLES(SC)) dut (.clock(clock), .srst(srst),
    .safing_sense_in(sense), .firing_enable_line_in(line), .closure_flag_out(flag),
    .firing_enable_line_out(od), .firing_enable_line_oe(oe), .firing_enable_seen(seen));
  sce_mcu_model mcu (.dut_oe(oe), .dut_out(od), .test_pull(pull), .line(line));
  task automatic cyc(input int k);
    repeat (k) @(posedge clock);
  endtask
  task automatic chk(input logic g, input logic e);
    checks++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %0t level mismatch", $time);
    end
  endtask
  task automatic chk_n(input int g, input int e);
    checks++;
    if (g != e) begin
      errors++;
      $display("[FAIL] %0t count %0d", $time, g);
    end
  endtask
  // Bounded wait for the pull, then count its cycles
  task automatic oe_len(output int k);
    k = 0;
    for (int i = 0; i < 3000 && !oe; i++) @(posedge clock);
    while (oe && k < 2000) begin
      @(posedge clock);
      k++;
    end
  endtask
  task automatic t_short();
    sense <= 1'b0;
    cyc(3);
    sense <= 1'b1;
    cyc(3);
    chk(flag, 1'b1);
    cyc(20);
    chk(flag, 1'b0);
    chk(oe, 1'b0);
    $display("t_short done");
  endtask
  task automatic t_ext();
    sense <= 1'b0;
    fork
      oe_len(n);
      begin
        cyc(112);
        chk(seen, 1'b0);
        chk(od, 1'b0);
        sense <= 1'b1;
        cyc(3);
        sense <= 1'b0;
        cyc(3);
        sense <= 1'b1;
      end
    join
    chk_n(n, EXT);
    chk(flag, 1'b1);
    cyc(2 * SC);
    chk(flag, 1'b0);
    $display("t_ext done");
  endtask
  task automatic t_retrig();
    sense <= 1'b0;
    oe_len(n);
    chk_n(n, EXT);
    oe_len(n);
    chk_n(n, EXT);
    sense <= 1'b1;
    cyc(3 * SC);
    chk(flag, 1'b0);
    $display("t_retrig done");
  endtask
  task automatic t_test();
    pull <= 1'b1;
    cyc(8);
    chk(seen, 1'b0);
    chk(flag, 1'b0);
    pull <= 1'b0;
    cyc(8);
    chk(seen, 1'b1);
    $display("t_test done");
  endtask
  // Long interruption inside the extension, then a fresh closure restarts it
  task automatic t_rearm();
    sense <= 1'b0;
    fork
      oe_len(n);
      begin
        cyc(40 * SC);
        sense <= 1'b1;
        cyc(2 * SC);
        sense <= 1'b0;
        cyc(5 * SC);
        sense <= 1'b1;
      end
    join
    chk(n >= EXT + 40 * SC && n <= EXT + 48 * SC, 1'b1);
    chk(flag, 1'b1);
    cyc(2 * SC);
    chk(flag, 1'b0);
    $display("t_rearm done");
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    cyc(12);
    srst <= 1'b0;
    cyc(2);
    t_short();
    t_ext();
    t_retrig();
    t_test();
    t_rearm();
    final_report();
  end
  initial begin
    cyc(6000);
    errors++;
    $display("[FAIL] %0t timeout", $time);
    final_report();
  end
endmodule // tb

// ===== include/sce_pkg.sv
package sce_pkg;
  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_HZ = 125000000;
  localparam int unsigned OSC_HZ = 100000;
  // Sample period is fifty oscillator periods
  localparam int unsigned SAMPLE_OSC_PERIODS = 50;
  localparam longint unsigned SAMPLE_CYC =
    (longint'(CLK_HZ) * SAMPLE_OSC_PERIODS) / OSC_HZ;
  localparam int unsigned SAMPLE_NS = 500000;
  // Times in microseconds, converted to sample ticks
  localparam int unsigned T_ADD_US = 96500;
  localparam int unsigned T_HALF_US = 500;
  localparam int unsigned T_ONE_US = 1000;
  localparam int unsigned SAMPLE_US = SAMPLE_NS / 1000;
  localparam int unsigned ADD_TICKS = T_ADD_US / SAMPLE_US;
  localparam int unsigned HALF_TICKS = (T_HALF_US + SAMPLE_US - 1) / SAMPLE_US;
  localparam int unsigned ONE_TICKS = (T_ONE_US + SAMPLE_US - 1) / SAMPLE_US;
  localparam int unsigned TICK_W = 9;
  localparam int unsigned DIV_W = 16;
endpackage

// ===== src/sce_closure_extender.sv
`timescale 1ns/1ns
module sce_closure_extender
  import sce_pkg::*;
#(
  parameter int unsigned SAMPLE_CYCLES = 32'(SAMPLE_CYC)
) (
  input wire logic clock, // 125 MHz clock
  input wire logic srst, // Synchronous reset, active high
  input wire logic safing_sense_in, // Comparator flag, low means closure
  input wire logic firing_enable_line_in, // Level seen on firing-enable wire
  output logic closure_flag_out, // High while closure reported
  output logic firing_enable_line_out, // Driven level, always low
  output logic firing_enable_line_oe, // High while pulling the line low
  output logic firing_enable_seen // Synchronised firing-enable level
);

  // Idle: output follows the inverted sense
  // Extension: output high and the firing-enable line pulled low
  // Hold: extension over, output still high until the sensor opens or retriggers
  typedef enum logic [2:0] {
    SCE_IDLE = 3'b001,
    SCE_EXT = 3'b010,
    SCE_HOLD = 3'b100
  } sce_state_t;

  // ****************************************
  // Input synchroniser
  // ****************************************
  // Three flops guard against metastability; a level counts only when the
  // last two agree, which also rejects a one-cycle glitch
  logic [2:0] sense_sync_ff;
  logic [2:0] fen_sync_ff;
  logic sense_ff;
  logic fen_ff;
  logic nxt_sense;
  logic nxt_fen;

  always_comb begin
    nxt_sense = sense_ff;
    if (sense_sync_ff[2] == sense_sync_ff[1]) begin
      nxt_sense = sense_sync_ff[2];
    end
    nxt_fen = fen_ff;
    if (fen_sync_ff[2] == fen_sync_ff[1]) begin
      nxt_fen = fen_sync_ff[2];
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      // Reset assumes an open sensor so release brings no false closure edge
      sense_sync_ff <= 3'h7;
      fen_sync_ff <= 3'h7;
      sense_ff <= 1'h1;
      fen_ff <= 1'h1;
    end else begin
      sense_sync_ff <= {sense_sync_ff[1:0], safing_sense_in};
      fen_sync_ff <= {fen_sync_ff[1:0], firing_enable_line_in};
      sense_ff <= nxt_sense;
      fen_ff <= nxt_fen;
    end
  end

  // ****************************************
  // Sample clock divider
  // ****************************************
  // One tick is one sample period; all durations are counted in ticks
  logic [DIV_W-1:0] div_ff;
  logic [DIV_W-1:0] nxt_div;
  logic tick;

  always_comb begin
    tick = (div_ff == DIV_W'(SAMPLE_CYCLES - 1));
    nxt_div = tick ? '0 : div_ff + DIV_W'(1);
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      div_ff <= '0;
    end else begin
      div_ff <= nxt_div;
    end
  end

  // ****************************************
  // Extension state machine
  // ****************************************
  sce_state_t state_ff;
  sce_state_t nxt_state;
  // Last two samples, newest in bit 0
  logic [1:0] smp_ff;
  logic [1:0] nxt_smp;
  // Ticks inside the extension, then ticks inside the hold
  logic [TICK_W-1:0] ext_ff;
  logic [TICK_W-1:0] nxt_ext;
  logic [TICK_W-1:0] low_ff;
  logic [TICK_W-1:0] nxt_low;
  logic [TICK_W-1:0] high_ff;
  logic [TICK_W-1:0] nxt_high;
  // Set by an interruption long enough to allow a retrigger
  logic armed_ff;
  logic nxt_armed;
  logic flag_ff;
  logic nxt_flag;
  logic oe_ff;
  logic nxt_oe;
  logic trig;

  // Saturating count: a very long closure must not wrap and look short
  function automatic logic [TICK_W-1:0] sat_inc(input logic [TICK_W-1:0] v);
    sat_inc = (&v) ? v : v + TICK_W'(1);
  endfunction

  // Sensor seen open for at least half a millisecond, this sample included
  function automatic logic open_long(input logic s, input logic [TICK_W-1:0] hi);
    open_long = s && (hi >= TICK_W'(HALF_TICKS - 1));
  endfunction

  // Sensor seen closed for at least one millisecond, this sample included
  function automatic logic closed_long(input logic s, input logic [TICK_W-1:0] lo);
    closed_long = !s && (lo >= TICK_W'(ONE_TICKS - 1));
  endfunction

  always_comb begin
    nxt_state = state_ff;
    nxt_smp = smp_ff;
    nxt_ext = ext_ff;
    nxt_low = low_ff;
    nxt_high = high_ff;
    nxt_armed = armed_ff;
    trig = 1'b0;
    if (tick) begin
      nxt_smp = {smp_ff[0], sense_ff};
      // Sampled high then low then low
      trig = smp_ff[1] && !smp_ff[0] && !sense_ff;
      nxt_low = sense_ff ? '0 : sat_inc(low_ff);
      nxt_high = sense_ff ? sat_inc(high_ff) : '0;
      case (state_ff)
        SCE_IDLE: begin
          // A closure that ends before the second low sample never starts one
          if (trig) begin
            nxt_state = SCE_EXT;
            nxt_ext = '0;
            nxt_armed = 1'b0;
          end
        end
        SCE_EXT: begin
          nxt_ext = sat_inc(ext_ff);
          // Long interruption arms a retrigger; short ones change nothing
          if (open_long(sense_ff, high_ff)) begin
            nxt_armed = 1'b1;
          end
          if (armed_ff && closed_long(sense_ff, low_ff)) begin
            nxt_ext = '0;
            nxt_armed = 1'b0;
          end else if (ext_ff == TICK_W'(ADD_TICKS - 1)) begin
            nxt_state = SCE_HOLD;
            nxt_ext = '0;
          end
        end
        SCE_HOLD: begin
          nxt_ext = sat_inc(ext_ff);
          // Closure must outlast the extension end by a full millisecond
          if (closed_long(sense_ff, low_ff) && ext_ff >= TICK_W'(ONE_TICKS - 1)) begin
            nxt_state = SCE_EXT;
            nxt_ext = '0;
            nxt_armed = 1'b0;
          end else if (open_long(sense_ff, high_ff)) begin
            nxt_state = SCE_IDLE;
          end
        end
        default: begin
          nxt_state = SCE_IDLE;
        end
      endcase
    end
    // In idle the output simply follows the inverted sense; extension and hold keep it high
    nxt_flag = (nxt_state == SCE_IDLE) ? !sense_ff : 1'b1;
    nxt_oe = (nxt_state == SCE_EXT);
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state_ff <= SCE_IDLE;
      smp_ff <= 2'h3;
      ext_ff <= '0;
      low_ff <= '0;
      high_ff <= '0;
      armed_ff <= 1'h0;
      flag_ff <= 1'h0;
      oe_ff <= 1'h0;
    end else begin
      state_ff <= nxt_state;
      smp_ff <= nxt_smp;
      ext_ff <= nxt_ext;
      low_ff <= nxt_low;
      high_ff <= nxt_high;
      armed_ff <= nxt_armed;
      flag_ff <= nxt_flag;
      oe_ff <= nxt_oe;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // The line is open drain: only the enable moves, the driven level stays low
  // Kept as a flop so every output leaves a register
  logic fen_out_ff;

  always_ff @(posedge clock) begin
    fen_out_ff <= 1'h0;
  end

  assign closure_flag_out = flag_ff;
  assign firing_enable_line_oe = oe_ff;
  assign firing_enable_line_out = fen_out_ff;
  // Controller may pull the line low itself for sensor tests
  // The extension never depends on this level; it is only reported
  assign firing_enable_seen = fen_ff;

endmodule // sce_closure_extender
